//--- pkg/power_ctrl_status_pkg.sv
// Constants and carrier types for the power management register bank
`default_nettype none
package power_ctrl_status_pkg;
    // Configuration dword holding the control/status word and data byte
    localparam logic [7:0] POWER_CTRL_STATUS_CFG_OFFSET   = 8'hE0;
    // Field positions in the control/status word
    localparam int         POWER_CTRL_STATUS_STATUS_BIT   = 15;
    localparam int         POWER_CTRL_STATUS_SCALE_HI     = 14;
    localparam int         POWER_CTRL_STATUS_SCALE_LO     = 13;
    localparam int         POWER_CTRL_STATUS_SEL_HI       = 12;
    localparam int         POWER_CTRL_STATUS_SEL_LO       = 9;
    localparam int         POWER_CTRL_STATUS_ENABLE_BIT   = 8;
    localparam int         POWER_CTRL_STATUS_PSTATE_HI    = 1;
    localparam int         POWER_CTRL_STATUS_PSTATE_LO    = 0;
    // Data byte position in the dword
    localparam int         POWER_CTRL_STATUS_DATA_LO      = 24;
    localparam int         POWER_CTRL_STATUS_DATA_HI      = 31;
    // Byte enable lanes
    localparam int         POWER_CTRL_STATUS_LANE_LOW     = 0;
    localparam int         POWER_CTRL_STATUS_LANE_HIGH    = 1;
    // Reset values
    localparam logic [1:0] POWER_CTRL_STATUS_PSTATE_RST   = 2'h0;
    localparam logic [3:0] POWER_CTRL_STATUS_SEL_RST      = 4'h0;
    // Scale codes and selector boundary
    localparam logic [1:0] POWER_CTRL_STATUS_SCALE_CENTI  = 2'h2;
    localparam logic [1:0] POWER_CTRL_STATUS_SCALE_NONE   = 2'h0;
    localparam logic [3:0] POWER_CTRL_STATUS_SEL_LAST     = 4'h8;
    localparam logic [3:0] POWER_CTRL_STATUS_SEL_D0_CONS  = 4'h0;
    localparam logic [3:0] POWER_CTRL_STATUS_SEL_D0_DISS  = 4'h4;
    // Power figures in 0.01 W units, earlier and later silicon
    localparam logic [7:0] POWER_CTRL_STATUS_PWR_D0_EARLY = 8'h3A;
    localparam logic [7:0] POWER_CTRL_STATUS_PWR_DX_EARLY = 8'h28;
    localparam logic [7:0] POWER_CTRL_STATUS_PWR_D0_LATE  = 8'h3C;
    localparam logic [7:0] POWER_CTRL_STATUS_PWR_DX_LATE  = 8'h2A;
    localparam logic [7:0] POWER_CTRL_STATUS_PWR_NONE     = 8'h00;

    typedef enum logic [1:0] {
        POWER_CTRL_STATUS_D0,
        POWER_CTRL_STATUS_D1,
        POWER_CTRL_STATUS_D2,
        POWER_CTRL_STATUS_D3
    } power_ctrl_status_pstate_type;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  offset;
        logic [3:0]  byte_en;
        logic [31:0] wdata;
    } power_ctrl_status_cfg_req_type;

    typedef struct packed {
        logic        ack;
        logic        retry;
        logic [31:0] rdata;
    } power_ctrl_status_cfg_rsp_type;
endpackage : power_ctrl_status_pkg
`default_nettype wire

//--- rtl/power_ctrl_status_bank.sv
// Power management control/status and power data register bank
//
// Operation
// - Wake event sets status bit 15 whatever the enable bit holds.
// - Writing one to status clears it; writing zero leaves it.
// - That clear also drops wake request and clears driver mirror bit.
// - With output enabled, wake request follows the status bit.
// - In CardBus mode, that clear also clears the general wake bit.
// - Scale field reads 10b for selector 0-8, 00b for 9-15.
// - Four-bit selector picks the data entry; software writes it.
// - Bit 8 enables wake request output; resets to zero.
// - Bits 7:5 and 3:2 read zero; writes ignored.
// - Dynamic data bit 4 always reads zero.
// - Power state bits 1:0 read/write, D0..D3, reset to D0.
// - Power data is an 8-bit read-only value for chosen entry.
// - Power data values are fixed constants in 0.01 W units.
// - Earlier step: 58 for 0,4; 40 for 1-3,5-7; else 00.
// - Later step: 60 for 0,4; 42 for 1-3,5-7; else 00.
// - Accesses before the EEPROM load completes are retried.
`timescale 1ns/1ps
`default_nettype none
module power_ctrl_status_bank #(
    parameter bit LATER_STEP = 1'b1
) (
    input  wire logic                         mclk,
    input  wire logic                         rst_n,
    input  wire power_ctrl_status_pkg::power_ctrl_status_cfg_req_type cfg_req,
    output      power_ctrl_status_pkg::power_ctrl_status_cfg_rsp_type cfg_rsp,
    input  wire logic                         eeprom_load_done,
    input  wire logic                         wake_event,
    input  wire logic                         cardbus_mode,
    output      logic                         general_wake_clear,
    output      logic                         driver_wake_clear,
    output      power_ctrl_status_pkg::power_ctrl_status_pstate_type  power_state,
    output      logic                         wake_request_out_n_o,
    output      logic                         wake_request_out_n_oe
);

    typedef struct packed {
        logic                        status;
        logic                        enable;
        logic [3:0]                  select;
        power_ctrl_status_pkg::power_ctrl_status_pstate_type pstate;
        power_ctrl_status_pkg::power_ctrl_status_cfg_rsp_type rsp;
        logic                        general_wake_flag_clr;
        logic                        drv_clr;
    } power_ctrl_status_state_type;

    power_ctrl_status_state_type state;
    power_ctrl_status_state_type next_state;

    logic [1:0]  scale;
    logic [7:0]  pwr_data;
    logic [15:0] csr_word;
    logic        hit;
    logic        wr_low;
    logic        wr_high;
    logic        clr_status;

    // Hard-coded table; the step is a build choice, not a strap
    always_comb begin
        if (state.select > power_ctrl_status_pkg::POWER_CTRL_STATUS_SEL_LAST) begin
            scale = power_ctrl_status_pkg::POWER_CTRL_STATUS_SCALE_NONE;
        end else begin
            scale = power_ctrl_status_pkg::POWER_CTRL_STATUS_SCALE_CENTI;
        end
        if (state.select >= power_ctrl_status_pkg::POWER_CTRL_STATUS_SEL_LAST) begin
            pwr_data = power_ctrl_status_pkg::POWER_CTRL_STATUS_PWR_NONE;
        end else if (state.select == power_ctrl_status_pkg::POWER_CTRL_STATUS_SEL_D0_CONS ||
                     state.select == power_ctrl_status_pkg::POWER_CTRL_STATUS_SEL_D0_DISS) begin
            pwr_data = LATER_STEP ? power_ctrl_status_pkg::POWER_CTRL_STATUS_PWR_D0_LATE
                                  : power_ctrl_status_pkg::POWER_CTRL_STATUS_PWR_D0_EARLY;
        end else begin
            pwr_data = LATER_STEP ? power_ctrl_status_pkg::POWER_CTRL_STATUS_PWR_DX_LATE
                                  : power_ctrl_status_pkg::POWER_CTRL_STATUS_PWR_DX_EARLY;
        end
    end

    // Reserved and dynamic bits stay zero by construction
    always_comb begin
        csr_word = '0;
        csr_word[power_ctrl_status_pkg::POWER_CTRL_STATUS_STATUS_BIT] = state.status;
        csr_word[power_ctrl_status_pkg::POWER_CTRL_STATUS_SCALE_HI:power_ctrl_status_pkg::POWER_CTRL_STATUS_SCALE_LO] = scale;
        csr_word[power_ctrl_status_pkg::POWER_CTRL_STATUS_SEL_HI:power_ctrl_status_pkg::POWER_CTRL_STATUS_SEL_LO] =
            state.select;
        csr_word[power_ctrl_status_pkg::POWER_CTRL_STATUS_ENABLE_BIT] = state.enable;
        csr_word[power_ctrl_status_pkg::POWER_CTRL_STATUS_PSTATE_HI:power_ctrl_status_pkg::POWER_CTRL_STATUS_PSTATE_LO] =
            state.pstate;
    end

    assign hit     = cfg_req.valid &&
                     cfg_req.offset == power_ctrl_status_pkg::POWER_CTRL_STATUS_CFG_OFFSET &&
                     eeprom_load_done;
    assign wr_low  = hit && cfg_req.write &&
                     cfg_req.byte_en[power_ctrl_status_pkg::POWER_CTRL_STATUS_LANE_LOW];
    assign wr_high = hit && cfg_req.write &&
                     cfg_req.byte_en[power_ctrl_status_pkg::POWER_CTRL_STATUS_LANE_HIGH];
    assign clr_status = wr_high &&
                        cfg_req.wdata[power_ctrl_status_pkg::POWER_CTRL_STATUS_STATUS_BIT];

    always_comb begin
        next_state = state;
        next_state.rsp.ack   = 1'b0;
        next_state.rsp.retry = 1'b0;
        next_state.general_wake_flag_clr = clr_status && cardbus_mode;
        next_state.drv_clr   = clr_status;
        // Set wins so an event in the clearing cycle is kept
        if (wake_event) begin
            next_state.status = 1'b1;
        end else if (clr_status) begin
            next_state.status = 1'b0;
        end
        if (wr_high) begin
            next_state.enable = cfg_req.wdata[power_ctrl_status_pkg::POWER_CTRL_STATUS_ENABLE_BIT];
            next_state.select = cfg_req.wdata[power_ctrl_status_pkg::POWER_CTRL_STATUS_SEL_HI:
                                              power_ctrl_status_pkg::POWER_CTRL_STATUS_SEL_LO];
        end
        if (wr_low) begin
            next_state.pstate = power_ctrl_status_pkg::power_ctrl_status_pstate_type'(
                cfg_req.wdata[power_ctrl_status_pkg::POWER_CTRL_STATUS_PSTATE_HI:
                              power_ctrl_status_pkg::POWER_CTRL_STATUS_PSTATE_LO]);
        end
        if (cfg_req.valid && !eeprom_load_done) begin
            next_state.rsp.retry = 1'b1;
        end else if (cfg_req.valid) begin
            next_state.rsp.ack = 1'b1;
        end
        // Unmapped offsets read zero; only reads return data
        if (hit && !cfg_req.write) begin
            next_state.rsp.rdata = '0;
            next_state.rsp.rdata[15:0] = csr_word;
            next_state.rsp.rdata[power_ctrl_status_pkg::POWER_CTRL_STATUS_DATA_HI:
                                 power_ctrl_status_pkg::POWER_CTRL_STATUS_DATA_LO] = pwr_data;
        end else if (cfg_req.valid && eeprom_load_done) begin
            // Retried accesses leave the last read data alone
            next_state.rsp.rdata = '0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state.status    <= 1'b0;
            state.enable    <= 1'b0;
            state.select    <= power_ctrl_status_pkg::POWER_CTRL_STATUS_SEL_RST;
            state.pstate    <= power_ctrl_status_pkg::POWER_CTRL_STATUS_D0;
            state.rsp       <= '0;
            state.general_wake_flag_clr <= 1'b0;
            state.drv_clr   <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    assign cfg_rsp            = state.rsp;
    assign general_wake_clear = state.general_wake_flag_clr;
    assign driver_wake_clear  = state.drv_clr;
    assign power_state        = state.pstate;
    // Open-drain: pull low only while enabled and flagged
    assign wake_request_out_n_o  = 1'b0;
    assign wake_request_out_n_oe = state.enable && state.status;

endmodule // power_ctrl_status_bank
`default_nettype wire

//--- testbench/power_ctrl_status_host.sv
// Host bridge model issuing configuration accesses
`timescale 1ns/1ps
`default_nettype none
module power_ctrl_status_host (
    input  wire logic                         mclk,
    output var  power_ctrl_status_pkg::power_ctrl_status_cfg_req_type cfg_req,
    input  wire power_ctrl_status_pkg::power_ctrl_status_cfg_rsp_type cfg_rsp
);
    initial cfg_req = '0;
    // One-cycle request; answer taken at the edge after the taking edge
    task automatic xfer(input logic wr, input logic [7:0] off,
                        input logic [3:0] be, input logic [31:0] wd,
                        output power_ctrl_status_pkg::power_ctrl_status_cfg_rsp_type rsp);
        @(posedge mclk);
        cfg_req <= '{1'b1, wr, off, be, wd};
        @(posedge mclk);
        // Released lines show garbage, not the last value
        cfg_req <= '{1'b0, ~wr, ~off, ~be, ~wd};
        @(posedge mclk);
        rsp = cfg_rsp;
    endtask
endmodule // power_ctrl_status_host
`default_nettype wire

//--- testbench/power_ctrl_status_bank_sva.sv
// Port-level checker for the power management register bank
`timescale 1ns/1ps
`default_nettype none
module power_ctrl_status_bank_sva #(parameter bit LATER_STEP = 1'b1) (
    input wire logic mclk, rst_n, eeprom_load_done, wake_event, cardbus_mode,
    input wire power_ctrl_status_pkg::power_ctrl_status_cfg_req_type cfg_req,
    input wire power_ctrl_status_pkg::power_ctrl_status_cfg_rsp_type cfg_rsp,
    input wire logic general_wake_clear, driver_wake_clear,
    input wire power_ctrl_status_pkg::power_ctrl_status_pstate_type power_state,
    input wire logic wake_request_out_n_o, wake_request_out_n_oe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic hit, clr_wr, rd_hit;
    assign hit = cfg_req.valid && eeprom_load_done
        && cfg_req.offset == power_ctrl_status_pkg::POWER_CTRL_STATUS_CFG_OFFSET;
    assign clr_wr = hit && cfg_req.write && cfg_req.byte_en[1]
        && cfg_req.wdata[15];
    assign rd_hit = hit && !cfg_req.write;
    answer_once_a: assert property (
        cfg_req.valid |=> cfg_rsp.ack != cfg_rsp.retry) else $error("answer");
    early_retry_a: assert property (
        cfg_req.valid && !eeprom_load_done |=> cfg_rsp.retry)
        else $error("retry");
    drv_clear_a: assert property (
        clr_wr |=> driver_wake_clear) else $error("driver clear");
    general_wake_flag_clear_a: assert property (
        clr_wr && cardbus_mode |=> general_wake_clear) else $error("general_wake_flag");
    req_drop_a: assert property (
        clr_wr && !wake_event |=> !wake_request_out_n_oe) else $error("drop");
    open_drain_a: assert property (
        wake_request_out_n_oe |-> !wake_request_out_n_o) else $error("od");
    pstate_wr_a: assert property (
        hit && cfg_req.write && cfg_req.byte_en[0] |=>
        power_state == $past(cfg_req.wdata[1:0])) else $error("pstate");
    zero_bits_a: assert property (
        cfg_rsp.ack && $past(rd_hit) |-> cfg_rsp.rdata[7:2] == 6'h00)
        else $error("reserved");
    scale_a: assert property (
        cfg_rsp.ack && $past(rd_hit) |-> cfg_rsp.rdata[14:13] ==
        (cfg_rsp.rdata[12:9] <= 4'h8 ? 2'h2 : 2'h0)) else $error("scale");
    data_hi_a: assert property (
        cfg_rsp.ack && $past(rd_hit) && cfg_rsp.rdata[12:9] >= 4'h8
        |-> cfg_rsp.rdata[31:24] == 8'h00) else $error("data");
endmodule // power_ctrl_status_bank_sva
bind power_ctrl_status_bank power_ctrl_status_bank_sva #(.LATER_STEP(LATER_STEP)) u_sva (.mclk,
    .rst_n, .eeprom_load_done, .wake_event, .cardbus_mode, .cfg_req,
    .cfg_rsp, .general_wake_clear, .driver_wake_clear, .power_state,
    .wake_request_out_n_o, .wake_request_out_n_oe);
`default_nettype wire

//--- testbench/tb.sv
// Self-checking testbench for the power management register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic mclk, rst_n, done, wake, cbus, gclr, dclr, od_o, od_oe;
    power_ctrl_status_pkg::power_ctrl_status_cfg_req_type req;
    power_ctrl_status_pkg::power_ctrl_status_cfg_rsp_type rsp, r;
    power_ctrl_status_pkg::power_ctrl_status_pstate_type  pst;
    int fail_count = 0, checks = 0, seed = 32'h17993F40, st, en, sel, ps;
    logic [31:0] w;
    power_ctrl_status_bank dut (.mclk, .rst_n, .cfg_req(req), .cfg_rsp(rsp),
        .eeprom_load_done(done), .wake_event(wake), .cardbus_mode(cbus),
        .general_wake_clear(gclr), .driver_wake_clear(dclr),
        .power_state(pst), .wake_request_out_n_o(od_o),
        .wake_request_out_n_oe(od_oe));
    power_ctrl_status_host host (.mclk, .cfg_req(req), .cfg_rsp(rsp));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic chk(string n, logic [31:0] e, logic [31:0] s);
        checks++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    function automatic logic [31:0] exp_rd();
        logic [7:0] d = (sel == 0 || sel == 4) ? 8'h3C
                      : (sel < 8 ? 8'h2A : 8'h00);
        return {d, 8'h00, st[0], (sel <= 8) ? 2'h2 : 2'h0, sel[3:0], en[0],
                6'h00, ps[1:0]};
    endfunction
    task automatic rd();
        host.xfer(1'b0, power_ctrl_status_pkg::POWER_CTRL_STATUS_CFG_OFFSET, 4'hF, 32'h0, r);
        chk("csr_read", exp_rd(), r.rdata);
    endtask
    // Model follows the write only on lanes 0 and 1
    task automatic wr(input logic [31:0] d);
        host.xfer(1'b1, power_ctrl_status_pkg::POWER_CTRL_STATUS_CFG_OFFSET, 4'h3, d, r);
        if (d[15]) st = 0;
        en = d[8];
        sel = d[12:9];
        ps = d[1:0];
    endtask
    task automatic end_sim();
        if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge mclk);
        fail_count++;
        end_sim();
    end
    initial begin
        {rst_n, done, wake, cbus, st, en, sel, ps} = '0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        host.xfer(1'b0, power_ctrl_status_pkg::POWER_CTRL_STATUS_CFG_OFFSET, 4'hF, 32'h0, r);
        chk("early_retry", 32'h1, r.retry);
        done <= 1'b1;
        rd();
        for (int i = 0; i < 16; i++) begin
            w = $random(seed);
            w[15] = 1'b0;
            w[12:9] = i[3:0];
            w[1:0] = i[1:0];
            wr(w);
            chk("power_state", ps, pst);
            rd();
        end
        wr(32'h0);
        @(posedge mclk) wake <= 1'b1;
        @(posedge mclk) wake <= 1'b0;
        st = 1;
        @(posedge mclk);
        chk("oe_disabled", 32'h0, od_oe);
        rd();
        wr(32'h100);
        chk("oe_follows", 32'h1, od_oe);
        rd();
        cbus <= 1'b1;
        wr(32'h8100);
        chk("driver_clear", 32'h1, dclr);
        chk("general_wake_flag_clear", 32'h1, gclr);
        chk("oe_cleared", 32'h0, od_oe);
        rd();
        host.xfer(1'b1, 8'hE4, 4'hF, 32'hFFFFFFFF, r);
        host.xfer(1'b0, 8'hE4, 4'hF, 32'h0, r);
        chk("unmapped", 32'h0, r.rdata);
        rd();
        end_sim();
    end
endmodule // tb
`default_nettype wire
